// file: core/sdmr_top.sv
// sdram mode register file: register-read/write decode, init status,
// pin self-test, burst configuration and burst column order generator
// assumes commands arrive as one-cycle strobes synchronous to CLK_IN
`timescale 1ns/10ps
`default_nettype none
`include "sdmr_params.svh"

module sdmr_top #(
    parameter int INIT_CYCLES = 1000
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire sdmr_pkg::sdmr_cmd_t CMD_IN,
    input wire logic [1:0] PIN_SELFTEST_IN,
    input wire logic [3:0] START_COL_IN,
    input wire logic [3:0] BEAT_IN,
    input wire logic WRITE_AP_IN,
    output sdmr_pkg::sdmr_resp_t RESP_OUT,
    output sdmr_pkg::sdmr_cfg_t CFG_OUT,
    output logic [3:0] BEAT_COL_OUT,
    output logic PRECHARGE_OUT,
    output logic CAL_BUSY_OUT,
    output logic DATA_CAL_OUT,
    output logic [7:0] TRIM_OUT
);
    import sdmr_pkg::*;

    localparam int INIT_LIMIT = `SDMR_INIT_MAX_US * 1000 / `SDMR_CLK_PERIOD_NS;
    localparam int CAL_CYCLES = `SDMR_CAL_NS / `SDMR_CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    sdmr_state_t state_q, state_d;
    logic [2:0] bl_q;
    logic order_q, wrap_q;
    logic [2:0] wr_q;
    logic [1:0] selftest_q;
    logic [7:0] trim_q;
    logic [15:0] cnt_q;
    logic [3:0] ap_cnt_q;
    logic ap_busy_q;

    wire logic wr_cfg = CMD_IN.wr && CMD_IN.addr == `SDMR_ADDR_BURST_WR_CONFIG;
    wire logic wr_cal = CMD_IN.wr && CMD_IN.addr == `SDMR_ADDR_IMPEDANCE_CAL;
    wire logic wr_rst = CMD_IN.wr && CMD_IN.addr == `SDMR_ADDR_SOFT_RESET; // [RQ21]
    // an assembly error freezes the trim and blocks calibration
    wire logic pin_fault = selftest_q == `SDMR_ST_FLOATING ||
                           selftest_q == `SDMR_ST_GROUNDED; // [RQ11]
    wire logic cal_code = CMD_IN.data == `SDMR_CAL_INIT || CMD_IN.data == `SDMR_CAL_LONG ||
                          CMD_IN.data == `SDMR_CAL_SHORT || CMD_IN.data == `SDMR_CAL_RESET;
    wire logic cal_go = wr_cal && cal_code && !pin_fault && state_q == SDMR_IDLE; // [RQ11]
    wire logic cal_init = CMD_IN.data == `SDMR_CAL_INIT;

    // field candidates from a configuration write; reserved codes are dropped
    wire logic [2:0] new_bl = CMD_IN.data[2:0];
    wire logic [2:0] new_wr = CMD_IN.data[7:`SDMR_WR_LO];
    wire logic bl_ok = new_bl >= `SDMR_BL_CODE_4 && new_bl <= `SDMR_BL_CODE_16; // [RQ12]
    wire logic wr_ok = new_wr >= `SDMR_WR_CODE_MIN && new_wr <= `SDMR_WR_CODE_MAX; // [RQ15]

    // ---------------------------------------------------------------
    // device status byte and read mux
    // ---------------------------------------------------------------
    wire logic auto_init_status = state_q == SDMR_INIT;
    // reserved bits and the device type bit are forced to zero
    wire logic [7:0] status_byte = {3'h0, selftest_q, 1'b0, 1'b0, auto_init_status}; // [RQ3] [RQ7] [RQ8] [RQ9]
    // write-only and reserved addresses answer with zero data (undefined allowed)
    wire logic [7:0] rd_data =
        CMD_IN.addr == `SDMR_ADDR_DEVICE_INFO_STATUS ? status_byte :
        CMD_IN.addr == `SDMR_ADDR_TRAINING_A ? `SDMR_TRAIN_A :
        CMD_IN.addr == `SDMR_ADDR_TRAINING_B ? `SDMR_TRAIN_B : 8'h00; // [RQ1] [RQ4] [RQ20]

    // read answer registered one cycle after the command
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            RESP_OUT <= '0;
        end else begin
            RESP_OUT.valid <= CMD_IN.rd;
            RESP_OUT.strobe <= CMD_IN.rd; // strobe pulses high one cycle after every read [RQ4]
            RESP_OUT.data <= CMD_IN.rd ? rd_data : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // init / calibration sequencer
    // ---------------------------------------------------------------
    // init takes INIT_CYCLES, capped at the 10 us bound (1000 cycles)
    wire logic [15:0] init_end = 16'(INIT_CYCLES < INIT_LIMIT ? INIT_CYCLES : INIT_LIMIT);
    wire logic cnt_done_init = cnt_q >= init_end - 16'h1;
    wire logic cnt_done_cal = cnt_q >= 16'(CAL_CYCLES - 1);
    logic cal_is_init_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SDMR_INIT: if (cnt_done_init) state_d = SDMR_IDLE; // [RQ22]
            SDMR_IDLE: if (cal_go) state_d = SDMR_CAL;
            SDMR_CAL: if (cnt_done_cal) state_d = SDMR_IDLE;
            default: state_d = SDMR_INIT;
        endcase
        if (wr_rst) state_d = SDMR_INIT;
    end

    // sequencer state and shared counter
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_q <= SDMR_INIT;
            cnt_q <= 16'h0;
            cal_is_init_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q || wr_rst) ? 16'h0 : cnt_q + 16'h1;
            if (cal_go) cal_is_init_q <= cal_init;
        end
    end

    // self-test latched when init calibration completes; trim held on a fault
    wire logic cal_finish = state_q == SDMR_CAL && cnt_done_cal && !wr_rst;
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            selftest_q <= `SDMR_RST_SELFTEST;
            trim_q <= `SDMR_RST_TRIM;
        end else if (cal_finish) begin
            if (cal_is_init_q) selftest_q <= PIN_SELFTEST_IN; // [RQ10]
            if (!(cal_is_init_q && PIN_SELFTEST_IN != `SDMR_ST_PASSED))
                trim_q <= trim_q ^ 8'h01; // model of a trim step [RQ11]
        end
    end

    // ---------------------------------------------------------------
    // burst configuration register
    // ---------------------------------------------------------------
    // reads-only addresses never reach these flops [RQ6]
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            bl_q <= `SDMR_RST_BL;
            order_q <= `SDMR_RST_ORDER;
            wrap_q <= `SDMR_RST_WRAP;
            wr_q <= `SDMR_RST_WR;
        end else if (wr_rst) begin
            bl_q <= `SDMR_RST_BL; // [RQ23]
            order_q <= `SDMR_RST_ORDER;
            wrap_q <= `SDMR_RST_WRAP;
            wr_q <= `SDMR_RST_WR;
        end else if (wr_cfg) begin
            if (bl_ok) bl_q <= new_bl; // [RQ24]
            order_q <= CMD_IN.data[`SDMR_BIT_BURST_ORDER]; // [RQ13]
            wrap_q <= CMD_IN.data[`SDMR_BIT_WRAP]; // [RQ14]
            if (wr_ok) wr_q <= new_wr; // [RQ24]
        end
    end

    wire logic [4:0] burst_len = bl_q == `SDMR_BL_CODE_16 ? 5'd16 :
                                 bl_q == `SDMR_BL_CODE_8 ? 5'd8 : 5'd4; // [RQ12]
    wire logic [3:0] wr_cycles = {1'b0, wr_q} + `SDMR_WR_CYCLE_BASE; // [RQ15]
    // no-wrap is only honoured at length 4
    wire logic no_wrap_eff = wrap_q && burst_len == 5'd4; // [RQ14]

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CFG_OUT <= '0;
        end else begin
            CFG_OUT.length <= burst_len;
            CFG_OUT.interleave <= order_q;
            CFG_OUT.no_wrap <= no_wrap_eff;
            CFG_OUT.wr_cycles <= wr_cycles;
        end
    end

    // ---------------------------------------------------------------
    // burst column order
    // ---------------------------------------------------------------
    // column bit 0 is implied zero for wrapping bursts; length 16 interleaved is unsupported [RQ17]
    wire logic [3:0] mask = burst_len == 5'd16 ? 4'hf : burst_len == 5'd8 ? 4'h7 : 4'h3;
    wire logic [3:0] start = {START_COL_IN[3:1], 1'b0};
    wire logic [3:0] seq_col = ((start + BEAT_IN) & mask) | (start & ~mask); // [RQ18] [RQ19]
    wire logic [3:0] int_col = ((start ^ BEAT_IN) & mask) | (start & ~mask); // [RQ19]
    wire logic [3:0] lin_col = START_COL_IN + (BEAT_IN & 4'h3); // [RQ18]
    wire logic [3:0] col_d = no_wrap_eff ? lin_col : (order_q ? int_col : seq_col);

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) BEAT_COL_OUT <= 4'h0;
        else BEAT_COL_OUT <= col_d;
    end

    // ---------------------------------------------------------------
    // write-recovery countdown before auto-precharge
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ap_cnt_q <= 4'h0;
            ap_busy_q <= 1'b0;
            PRECHARGE_OUT <= 1'b0;
        end else begin
            PRECHARGE_OUT <= ap_busy_q && ap_cnt_q == 4'h1; // [RQ16]
            if (WRITE_AP_IN) begin
                ap_cnt_q <= wr_cycles;
                ap_busy_q <= 1'b1;
            end else if (ap_busy_q) begin
                ap_cnt_q <= ap_cnt_q - 4'h1;
                if (ap_cnt_q == 4'h1) ap_busy_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CAL_BUSY_OUT <= 1'b0;
            DATA_CAL_OUT <= 1'b0;
        end else begin
            CAL_BUSY_OUT <= state_d == SDMR_CAL;
            // a training read marks a data-calibration access [RQ21]
            DATA_CAL_OUT <= CMD_IN.rd && (CMD_IN.addr == `SDMR_ADDR_TRAINING_A ||
                                          CMD_IN.addr == `SDMR_ADDR_TRAINING_B);
        end
    end
    assign TRIM_OUT = trim_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_read_strobe: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ4]
        CMD_IN.rd |=> RESP_OUT.valid && RESP_OUT.strobe)
        else $error("read not answered");
    chk_reserved_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ3]
        CMD_IN.rd && CMD_IN.addr == 8'h00 |=> RESP_OUT.data[7:5] == 3'h0 && !RESP_OUT.data[2])
        else $error("reserved bits set");
    chk_type_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ8]
        CMD_IN.rd && CMD_IN.addr == 8'h00 |=> !RESP_OUT.data[1])
        else $error("device type bit set");
    chk_init_bound: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ22]
        wr_rst ##1 !wr_rst [*1] |-> ##[0:1000] !auto_init_status || wr_rst)
        else $error("init too long");
    chk_rst_default: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ23]
        wr_rst |=> bl_q == 3'h2 && !order_q && !wrap_q && wr_q == 3'h1)
        else $error("defaults not restored");
    chk_bl_keep: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ24]
        wr_cfg && !wr_rst && !bl_ok |=> $stable(bl_q))
        else $error("reserved length taken");
    chk_fault_nocal: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ11]
        pin_fault |-> !cal_go)
        else $error("calibration on fault");
    chk_ro_ignore: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ6]
        CMD_IN.wr && CMD_IN.addr == 8'h00 |=> $stable(bl_q) && $stable(wr_q))
        else $error("read-only write acted");
    chk_precharge_time: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ16]
        WRITE_AP_IN && wr_cycles == 4'h3 ##1 !WRITE_AP_IN [*3] |=> PRECHARGE_OUT)
        else $error("precharge late");
    chk_train_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RQ20]
        CMD_IN.rd && CMD_IN.addr == 8'h20 |=> RESP_OUT.data == 8'h55)
        else $error("pattern a wrong");

endmodule
`default_nettype wire

// file: core/sdmr_params.svh
// constants for the sdram mode register file: offsets, fields, resets, timing
// assumes a 100 MHz core clock; included by the top module and the bench
//
// Behaviour
// RQ1: read or write byte chosen by register address
// RQ2: controller writes reserved bits as zero; the bench writes ffh to register 0, which wr_mask passes unmasked
// RQ3: reserved bits read back as zero
// RQ4: read of write-only/reserved still strobes, data undefined
// RQ5: controller never writes reserved register addresses
// RQ6: writes to read-only registers are ignored
// RQ7: bit 0 of register 0 shows init busy
// RQ8: bit 1 of register 0 reads zero
// RQ9: bits 4:3 of register 0 give pin self-test
// RQ10: self-test field updates when init calibration ends
// RQ11: assembly error keeps trim, ignores calibration commands
// RQ12: burst length codes 010/011/100 give 4/8/16
// RQ13: bit 3 selects sequential or interleaved order
// RQ14: bit 4 selects wrap; no-wrap only at length 4
// RQ15: write recovery codes 001..110 give 3..8 cycles
// RQ16: auto-precharge starts after write recovery count
// RQ17: controller avoids length 16 with interleaved order
// RQ18: four-beat order from column bit 1, or linear
// RQ19: eight-beat sequential and interleaved orders as tabled
// RQ20: fixed training patterns at addresses 20h and 28h
// RQ21: writes start calibration and reset at 3Fh
// RQ22: init status clears within 10 us of reset
// RQ23: reset command restores configuration defaults
// RQ24: reserved code leaves field value unchanged
`ifndef SDMR_PARAMS_SVH
`define SDMR_PARAMS_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define SDMR_ADDR_DEVICE_INFO_STATUS 8'h00
`define SDMR_ADDR_BURST_WR_CONFIG 8'h01
`define SDMR_ADDR_LATENCY_CONFIG 8'h02
`define SDMR_ADDR_OUTPUT_DRIVE_CONFIG 8'h03
`define SDMR_ADDR_REFRESH_RATE_STATUS 8'h04
`define SDMR_ADDR_MAKER_CODE 8'h05
`define SDMR_ADDR_REVISION_ONE 8'h06
`define SDMR_ADDR_REVISION_TWO 8'h07
`define SDMR_ADDR_GEOMETRY_INFO 8'h08
`define SDMR_ADDR_TEST_MODE 8'h09
`define SDMR_ADDR_IMPEDANCE_CAL 8'h0a
`define SDMR_ADDR_REFRESH_BANK_MASK 8'h10
`define SDMR_ADDR_REFRESH_SEG_MASK 8'h11
`define SDMR_ADDR_TRAINING_A 8'h20
`define SDMR_ADDR_TRAINING_B 8'h28
`define SDMR_ADDR_SOFT_RESET 8'h3f

// ---------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------
`define SDMR_BIT_AUTO_INIT 0
`define SDMR_BIT_DEVICE_TYPE 1
`define SDMR_SELFTEST_LO 3
`define SDMR_BIT_BURST_ORDER 3
`define SDMR_BIT_WRAP 4
`define SDMR_WR_LO 5
`define SDMR_BL_CODE_4 3'h2
`define SDMR_BL_CODE_8 3'h3
`define SDMR_BL_CODE_16 3'h4
`define SDMR_WR_CODE_MIN 3'h1
`define SDMR_WR_CODE_MAX 3'h6
`define SDMR_WR_CYCLE_BASE 4'h2
`define SDMR_ST_FLOATING 2'h1
`define SDMR_ST_GROUNDED 2'h2
`define SDMR_ST_PASSED 2'h3
`define SDMR_CAL_INIT 8'hff
`define SDMR_CAL_LONG 8'hab
`define SDMR_CAL_SHORT 8'h56
`define SDMR_CAL_RESET 8'hc3

// ---------------------------------------------------------------
// reset values and fixed read data
// ---------------------------------------------------------------
`define SDMR_RST_BL 3'h2
`define SDMR_RST_ORDER 1'b0
`define SDMR_RST_WRAP 1'b0
`define SDMR_RST_WR 3'h1
`define SDMR_RST_SELFTEST 2'h0
`define SDMR_RST_TRIM 8'h80
`define SDMR_TRAIN_A 8'h55
`define SDMR_TRAIN_B 8'h33

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SDMR_CLK_PERIOD_NS 10
`define SDMR_INIT_MAX_US 10
`define SDMR_CAL_NS 1000

`endif

// file: core/sdmr_pkg.sv
// types for the sdram mode register file
// assumes sdmr_params.svh is on the include path
package sdmr_pkg;

    // ---------------------------------------------------------------
    // command bus and read answer
    // ---------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } sdmr_cmd_t;

    typedef struct packed {
        logic valid;
        logic strobe;
        logic [7:0] data;
    } sdmr_resp_t;

    // decoded burst configuration
    typedef struct packed {
        logic [4:0] length;
        logic interleave;
        logic no_wrap;
        logic [3:0] wr_cycles;
    } sdmr_cfg_t;

    typedef enum logic [1:0] {
        SDMR_INIT,
        SDMR_IDLE,
        SDMR_CAL
    } sdmr_state_t;

endpackage

// file: tb/sdmr_ctrl_model.sv
// controller model: issues register read and write commands on the command bus
// assumes the bench calls its tasks; the bus changes 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none

module sdmr_ctrl_model (
    input wire logic clk_in,
    input wire sdmr_pkg::sdmr_resp_t resp_in,
    output var sdmr_pkg::sdmr_cmd_t cmd_out
);
    import sdmr_pkg::*;

    // bus idle from time zero
    initial cmd_out = '0;

    // bits the controller may set per address; zero marks an address never written
    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        case (a)
            8'h02, 8'h03: return 8'h0f; // upper nibble reserved
            8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
            8'h10, 8'h11, 8'h20, 8'h28, 8'h3f: return 8'hff;
            default: return 8'h00; // reserved address
        endcase
    endfunction

    // one write strobe; gap idles first so slow controllers are covered too
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
        if (wr_mask(a) == 8'h00) return;
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        #1 cmd_out = '{rd: 1'b0, wr: 1'b1, addr: a, data: d & wr_mask(a)};
        @(posedge clk_in);
        #1 cmd_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d}; // released lines do not hold
    endtask

    // one read strobe; the answer is taken in the cycle where valid shows
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic stb);
        d = 8'hxx;
        stb = 1'b0;
        @(posedge clk_in);
        #1 cmd_out = '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
        @(posedge clk_in);
        #1 cmd_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: 8'hff};
        for (int n = 0; n < 4; n++) begin
            if (resp_in.valid === 1'b1) begin
                d = resp_in.data;
                stb = resp_in.strobe;
                break;
            end
            @(posedge clk_in);
            #1;
        end
    endtask
endmodule

`default_nettype wire

// file: tb/sdram_mode_register_file_bench.sv
// bench for the mode register file: access, config, burst order, calibration
// assumes the core/ design files and the controller model in tb/
`timescale 1ns/10ps
`default_nettype none
`include "sdmr_params.svh"

module sdram_mode_register_file_bench;
    import sdmr_pkg::*;

    localparam int INIT_CYC = 20;
    localparam sdmr_cfg_t cfg_rst = '{length: 5'h04, interleave: 1'b0, no_wrap: 1'b0,
        wr_cycles: 4'h3};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pin_st = 2'b11;
    logic [3:0] scol = 4'h0;
    logic [3:0] beat = 4'h0;
    logic ap = 1'b0;
    sdmr_cmd_t cmd;
    sdmr_resp_t resp;
    sdmr_cfg_t cfg;
    sdmr_cfg_t exp_cfg;
    logic [3:0] bcol;
    logic [7:0] trim;
    logic pre;
    logic busy;
    logic dcal;
    logic [7:0] rdat;
    logic rstb;
    int num_errors = 0;
    int checked = 0;
    int cal_pulses = 0;
    int pulse_base;
    // table holds no wide no-wrap and no 16-beat interleave
    logic [7:0] cfg_tab [8] = '{8'h22, 8'h52, 8'h63, 8'h8b, 8'ha4, 8'hca, 8'h08, 8'hf7};
    logic [7:0] rd_tab [4] = '{8'h20, 8'h28, 8'h01, 8'h0b};
    logic [7:0] rd_exp [4] = '{`SDMR_TRAIN_A, `SDMR_TRAIN_B, 8'h00, 8'h00};
    logic [7:0] cal_tab [4] = '{`SDMR_CAL_LONG, `SDMR_CAL_SHORT, `SDMR_CAL_RESET, 8'h12};

    // 100 MHz clock; a strobe is counted at the edge that follows it
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (dcal === 1'b1) cal_pulses++;
    end

    sdmr_top #(.INIT_CYCLES(INIT_CYC)) u_sdmr_top (
        .CLK_IN(clk), .RESET_IN(rst), .CMD_IN(cmd), .PIN_SELFTEST_IN(pin_st),
        .START_COL_IN(scol), .BEAT_IN(beat), .WRITE_AP_IN(ap), .RESP_OUT(resp),
        .CFG_OUT(cfg), .BEAT_COL_OUT(bcol), .PRECHARGE_OUT(pre), .CAL_BUSY_OUT(busy),
        .DATA_CAL_OUT(dcal), .TRIM_OUT(trim));
    sdmr_ctrl_model u_sdmr_ctrl_model (.clk_in(clk), .resp_in(resp), .cmd_out(cmd));

    // ----------------------------------------------------------------
    // compares and bus helpers
    // ----------------------------------------------------------------
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_cfg(input sdmr_cfg_t exp, input sdmr_cfg_t got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch burst config expected %h seen %h", exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        u_sdmr_ctrl_model.read_reg(a, rdat, rstb);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_sdmr_ctrl_model.write_reg(a, d, 0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // reserved codes leave a field as it was
    function automatic sdmr_cfg_t next_cfg(input sdmr_cfg_t old, input logic [7:0] v);
        next_cfg = old;
        next_cfg.interleave = v[3];
        next_cfg.no_wrap = v[4];
        if (v[2:0] inside {3'h2, 3'h3, 3'h4}) next_cfg.length = 5'h04 << (v[2:0] - 3'h2);
        if (v[7:5] inside {[3'h1:3'h6]}) next_cfg.wr_cycles = {1'b0, v[7:5]} + 4'h2;
    endfunction
    function automatic logic [3:0] col_of(input sdmr_cfg_t c, input logic [3:0] s,
        input logic [3:0] b);
        logic [3:0] base;
        base = {s[3:1], 1'b0};
        if (c.no_wrap) return s + b;
        if (c.interleave) return base ^ b;
        return base + b;
    endfunction

    // ----------------------------------------------------------------
    // scenario steps
    // ----------------------------------------------------------------
    task automatic hard_reset();
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
    endtask
    task automatic wait_init();
        rd(8'h00);
        check_val("init busy", 8'h01, rdat & 8'h01);
        for (int n = 0; n < INIT_CYC && rdat[0] !== 1'b0; n++) rd(8'h00);
        check_val("init done", 8'h00, 8'(rdat[0]));
    endtask
    // only the low column bits of a wrapping burst are defined
    task automatic sweep(input sdmr_cfg_t c);
        logic [3:0] m;
        m = c.no_wrap ? 4'hf : 4'(c.length - 5'h01);
        for (int s = 0; s < (c.no_wrap ? 13 : 16); s += 2) begin
            for (int b = 0; b < int'(c.length); b++) begin
                scol = 4'(s);
                beat = 4'(b);
                @(posedge clk);
                #1 check_val("beat column", 8'(col_of(c, scol, beat) & m), 8'(bcol & m));
            end
        end
    endtask
    task automatic check_pre(input logic [3:0] cyc);
        int n;
        ap = 1'b1;
        @(posedge clk);
        #1 ap = 1'b0;
        for (n = 0; n < 20 && pre !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        // the pulse shows right after the programmed count of edges
        check_val("precharge delay", 8'(cyc), 8'(n));
    endtask
    task automatic run_cal(input logic [7:0] code, input logic runs);
        logic seen;
        seen = 1'b0;
        wr(`SDMR_ADDR_IMPEDANCE_CAL, code);
        for (int n = 0; n < 150; n++) begin
            if (busy === 1'b1) seen = 1'b1;
            if (seen && busy === 1'b0) break;
            @(posedge clk);
            #1;
        end
        check_val("calibration ran", 8'(runs), 8'(seen));
        check_val("calibration idle", 8'h00, 8'(busy));
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        hard_reset();
        wait_init();
        check_cfg(cfg_rst, cfg);
        $display("test reset defaults done");
        foreach (rd_tab[i]) begin
            pulse_base = cal_pulses;
            rd(rd_tab[i]);
            check_val("read data", rd_exp[i], rdat);
            check_val("read strobe", 8'h01, 8'(rstb));
            repeat (2) @(posedge clk);
            #1 check_val("data cal", 8'(rd_tab[i][5]), 8'(cal_pulses - pulse_base));
        end
        wr(`SDMR_ADDR_DEVICE_INFO_STATUS, 8'hff);
        wr(`SDMR_ADDR_TRAINING_A, 8'h00);
        rd(8'h00);
        check_val("status after write", 8'h00, rdat);
        rd(8'h20);
        check_val("pattern after write", `SDMR_TRAIN_A, rdat);
        $display("test reads done");
        exp_cfg = cfg_rst;
        foreach (cfg_tab[i]) begin
            exp_cfg = next_cfg(exp_cfg, cfg_tab[i]);
            u_sdmr_ctrl_model.write_reg(8'h01, cfg_tab[i], i % 3);
            repeat (2) @(posedge clk);
            #1 check_cfg(exp_cfg, cfg);
            sweep(exp_cfg);
            check_pre(exp_cfg.wr_cycles);
        end
        $display("test burst config done");
        wr(`SDMR_ADDR_SOFT_RESET, 8'h00);
        repeat (2) @(posedge clk);
        #1 check_cfg(cfg_rst, cfg);
        wait_init();
        $display("test soft reset done");
        for (int p = 1; p < 4; p++) begin
            pin_st = 2'(p);
            hard_reset();
            wait_init();
            run_cal(`SDMR_CAL_INIT, 1'b1);
            rd(8'h00);
            check_val("self test", {3'h0, pin_st, 3'h0}, rdat);
            if (p != 3) begin
                check_val("trim", `SDMR_RST_TRIM, trim);
                run_cal(`SDMR_CAL_LONG, 1'b0);
            end
        end
        foreach (cal_tab[i]) run_cal(cal_tab[i], cal_tab[i] != 8'h12);
        $display("test calibration done");
        close_out();
    end

    initial begin
        #200000;
        num_errors++;
        $display("watchdog expired");
        close_out();
    end
endmodule

`default_nettype wire
